// ### include/enc_pkg.sv
`default_nettype none
package enc_pkg;
	// Register indices; the byte address of each is four times its index
	localparam logic [11:0] IDX_CONTROL  = 12'h122;
	localparam logic [11:0] IDX_FILTER   = 12'h124;
	localparam logic [11:0] IDX_POSITION = 12'h126;
	localparam logic [11:0] IDX_MAXIMUM  = 12'h128;
	localparam logic [11:0] IDX_IRQ_FLAG = 12'h12A;

	// encoder_control_register fields
	localparam int CTRL_ERR_BIT    = 15;
	localparam int CTRL_IDXST_BIT  = 12;
	localparam int CTRL_DIR_BIT    = 11;
	localparam int CTRL_MODE_LSB   = 8;
	localparam int CTRL_INDEX_RESET_ENABLE_BIT = 2;
	localparam int CTRL_DSRC_BIT   = 0;

	// filter_control_register fields
	localparam int FLT_IMV_LSB   = 9;
	localparam int FLT_COUNT_ERROR_IRQ_DISABLE_BIT  = 8;
	localparam int FLT_OUTEN_BIT = 7;
	localparam int FLT_DIV_LSB   = 4;

	localparam logic [15:0] CONTROL_RESET  = 16'h0000;
	localparam logic [15:0] FILTER_RESET   = 16'h0000;
	localparam logic [15:0] POSITION_RESET = 16'h0000;
	localparam logic [15:0] MAXIMUM_RESET  = 16'hFFFF;

	// encoder_mode_field encodings
	localparam logic [2:0] MODE_OFF      = 3'h0;
	localparam logic [2:0] MODE_TIMER    = 3'h1;
	localparam logic [2:0] MODE_X2_INDEX = 3'h4;
	localparam logic [2:0] MODE_X2_MAX   = 3'h5;
	localparam logic [2:0] MODE_X4_INDEX = 3'h6;
	localparam logic [2:0] MODE_X4_MAX   = 3'h7;
endpackage
`default_nettype wire

// ### hw/quad_encoder.sv
// Functional notes
// - Phase A leading B means forward direction, lagging means reverse.
// - In modes 110 and 100, reaching max+1 or 0xFFFF sets count error and interrupt.
// - The count error interrupt disable bit suppresses the count error interrupt.
// - After a count error counting continues; natural rollover raises no interrupt.
// - Count error flag is read/write and stays set until software clears it.
// - In index modes, index reset enable set resets count on index; else wraps.
// - x4: index match needs B equal to upper and A to lower match bit.
// - x2: upper match bit picks phase, lower bit gives its required level.
// - Index modes interrupt on index detection, not on counter overflow.
// - Decoded direction drives an output pin and control bit 11, which software can write in timer mode.
// - Modes 100/101 count both edges of phase A only; B sets direction.
// - Mode 100 resets on index, mode 101 on maximum count match.
// - Modes 110/111 count every edge of both phases, except an A and a B edge in the same cycle.
// - Mode 110 resets on index, mode 111 on maximum count match.
// - Filter output changes only after three equal consecutive samples.
// - Filter sample clock divides the system clock by two to the power of the three-bit divide field.
// - Filtered inputs used only when filter output enable is 1; off after reset.
// - Timer mode 001 clocks the 16-bit timer from phase A.
// - Timer uses position count as count, maximum count as period; match sets flag.
// - Changing mode leaves the shared count register unchanged.
// - Timer direction from phase B if source bit set, else from direction bit.
// - External timer clock is always synchronised before counting.
// - Rollover in modes 101/111, qualified index, count error unless its interrupt is disabled, or period match set the sticky flag.
`default_nettype none
module quad_encoder
	import enc_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [15:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        phase_a_input_in,
	input  wire logic        phase_b_input_in,
	input  wire logic        index_input_in,
	output logic             count_direction_out,
	output logic             module_interrupt_flag_out,
	output logic             count_error_flag_out
);
	logic [2:0]  s1_reg, s2_reg, s3_reg, clean_reg, h1_reg, h2_reg, filt_reg, prev_reg;
	logic [7:0]  div_cnt_reg;
	logic [15:0] pos_reg, max_reg;
	logic [2:0]  mode_reg, fdiv_reg;
	logic [1:0]  imv_reg;
	logic        index_reset_enable_reg, dsrc_reg, count_error_flag_reg, dir_reg, irq_reg;
	logic        count_error_irq_disable_reg, fen_reg, pready_reg, pslverr_reg;
	logic [31:0] prdata_reg;

	// Bus decode
	wire logic        setup    = psel_in & ~penable_in;
	wire logic        wr       = psel_in & penable_in & pready_reg & pwrite_in;
	wire logic        hit_ctrl = paddr_in == {2'b00, IDX_CONTROL, 2'b00};
	wire logic        hit_flt  = paddr_in == {2'b00, IDX_FILTER, 2'b00};
	wire logic        hit_pos  = paddr_in == {2'b00, IDX_POSITION, 2'b00};
	wire logic        hit_max  = paddr_in == {2'b00, IDX_MAXIMUM, 2'b00};
	wire logic        hit_flag = paddr_in == {2'b00, IDX_IRQ_FLAG, 2'b00};
	wire logic        mapped   = hit_ctrl | hit_flt | hit_pos | hit_max | hit_flag;
	wire logic        wr_ctrl  = wr & hit_ctrl;
	wire logic        wr_flt   = wr & hit_flt;
	wire logic        wr_pos   = wr & hit_pos;
	wire logic        wr_max   = wr & hit_max;
	wire logic        wr_flag  = wr & hit_flag;

	// Input conditioning: sync, then optional three-sample filter
	wire logic [2:0]  pins      = {index_input_in, phase_b_input_in, phase_a_input_in};
	wire logic [2:0]  clean_nxt = (s2_reg & s3_reg) | (clean_reg & (s2_reg | s3_reg));
	wire logic [7:0]  div_limit = 8'((9'h001 << fdiv_reg) - 9'h001);
	// Compare with >= so a smaller divide after a larger one cannot stall the filter clock
	wire logic        tick      = div_cnt_reg >= div_limit;
	wire logic [2:0]  stable    = ~(clean_reg ^ h1_reg) & ~(h1_reg ^ h2_reg);
	wire logic [2:0]  filt_nxt  = (stable & clean_reg) | (~stable & filt_reg);
	wire logic [2:0]  sel       = fen_reg ? filt_reg : clean_reg;
	wire logic        ph_a      = sel[0];
	wire logic        ph_b      = sel[1];
	wire logic        ea        = sel[0] ^ prev_reg[0];
	wire logic        eb        = sel[1] ^ prev_reg[1];

	// Mode decode
	wire logic        is_x2    = (mode_reg == MODE_X2_INDEX) | (mode_reg == MODE_X2_MAX);
	wire logic        is_x4    = (mode_reg == MODE_X4_INDEX) | (mode_reg == MODE_X4_MAX);
	wire logic        idx_mode = (mode_reg == MODE_X2_INDEX) | (mode_reg == MODE_X4_INDEX);
	wire logic        max_mode = (mode_reg == MODE_X2_MAX) | (mode_reg == MODE_X4_MAX);
	wire logic        tmr      = mode_reg == MODE_TIMER;

	// Direction and count steps
	wire logic        enc_step = is_x2 ? ea : (is_x4 & (ea ^ eb));
	wire logic        enc_up   = ea ? (ph_a ^ ph_b) : ~(ph_a ^ ph_b);
	wire logic        tmr_step = tmr & ea & ph_a;
	wire logic        tmr_up   = dsrc_reg ? ph_b : dir_reg;
	wire logic        step     = enc_step | tmr_step;
	wire logic        up       = tmr ? tmr_up : enc_up;

	// Index qualification
	wire logic        idx_match = is_x4 ? (ph_b == imv_reg[1] && ph_a == imv_reg[0])
		: ((imv_reg[1] ? ph_b : ph_a) == imv_reg[0]);
	wire logic        idx_qual  = idx_mode & sel[2] & ~prev_reg[2] & idx_match;

	wire logic        at_top   = pos_reg == max_reg;
	wire logic        at_zero  = pos_reg == 16'h0000;
	wire logic        wrap_evt = (max_mode | tmr) & step & (up ? at_top : at_zero);
	// Up from max reaches max+1, down from zero reaches 0xFFFF
	wire logic        err_hit  = idx_mode & step & (up ? at_top : at_zero);
	// Natural rollover in index modes is deliberately absent from the set terms
	wire logic        irq_set  = wrap_evt | idx_qual | (err_hit & ~count_error_irq_disable_reg);

	logic [15:0] pos_next;
	always_comb begin
		// Mode changes never touch the count, so no mode term appears here
		if (wr_pos)
			pos_next = pwdata_in[15:0];
		else if (idx_qual & index_reset_enable_reg)
			pos_next = 16'h0000;
		else if (wrap_evt)
			pos_next = up ? 16'h0000 : max_reg;
		else if (step)
			pos_next = up ? pos_reg + 16'h0001 : pos_reg - 16'h0001;
		else
			pos_next = pos_reg;
	end

	// Hardware set wins over a software clear
	wire logic        count_error_flag_next = err_hit | (wr_ctrl ? pwdata_in[CTRL_ERR_BIT] : count_error_flag_reg);
	wire logic        irq_next    = irq_set | (irq_reg & ~(wr_flag & ~pwdata_in[0]));
	wire logic        dir_next    = tmr ? (wr_ctrl ? pwdata_in[CTRL_DIR_BIT] : dir_reg)
		: (enc_step ? enc_up : dir_reg);

	wire logic [15:0] ctrl_word = {count_error_flag_reg, 2'b00, sel[2], dir_reg, mode_reg, 5'b00000,
		index_reset_enable_reg, 1'b0, dsrc_reg};
	wire logic [15:0] flt_word  = {5'b00000, imv_reg, count_error_irq_disable_reg, fen_reg, fdiv_reg, 4'b0000};
	wire logic [15:0] rd_word   = hit_ctrl ? ctrl_word : hit_flt ? flt_word
		: hit_pos ? pos_reg : hit_max ? max_reg : {15'h0000, irq_reg};

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_reg      <= 3'h0;
			s2_reg      <= 3'h0;
			s3_reg      <= 3'h0;
			clean_reg   <= 3'h0;
			h1_reg      <= 3'h0;
			h2_reg      <= 3'h0;
			filt_reg    <= 3'h0;
			prev_reg    <= 3'h0;
			div_cnt_reg <= 8'h00;
		end else begin
			s1_reg      <= pins;
			s2_reg      <= s1_reg;
			s3_reg      <= s2_reg;
			clean_reg   <= clean_nxt;
			prev_reg    <= sel;
			div_cnt_reg <= tick ? 8'h00 : div_cnt_reg + 8'h01;
			if (tick) begin
				h1_reg   <= clean_reg;
				h2_reg   <= h1_reg;
				filt_reg <= filt_nxt;
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_reg   <= CONTROL_RESET[CTRL_MODE_LSB +: 3];
			index_reset_enable_reg <= CONTROL_RESET[CTRL_INDEX_RESET_ENABLE_BIT];
			dsrc_reg   <= CONTROL_RESET[CTRL_DSRC_BIT];
			count_error_flag_reg <= CONTROL_RESET[CTRL_ERR_BIT];
			dir_reg    <= CONTROL_RESET[CTRL_DIR_BIT];
			imv_reg    <= FILTER_RESET[FLT_IMV_LSB +: 2];
			count_error_irq_disable_reg   <= FILTER_RESET[FLT_COUNT_ERROR_IRQ_DISABLE_BIT];
			fen_reg    <= FILTER_RESET[FLT_OUTEN_BIT];
			fdiv_reg   <= FILTER_RESET[FLT_DIV_LSB +: 3];
			pos_reg    <= POSITION_RESET;
			max_reg    <= MAXIMUM_RESET;
			irq_reg    <= 1'b0;
		end else begin
			count_error_flag_reg <= count_error_flag_next;
			dir_reg    <= dir_next;
			pos_reg    <= pos_next;
			irq_reg    <= irq_next;
			if (wr_ctrl) begin
				mode_reg   <= pwdata_in[CTRL_MODE_LSB +: 3];
				index_reset_enable_reg <= pwdata_in[CTRL_INDEX_RESET_ENABLE_BIT];
				dsrc_reg   <= pwdata_in[CTRL_DSRC_BIT];
			end
			if (wr_flt) begin
				imv_reg  <= pwdata_in[FLT_IMV_LSB +: 2];
				count_error_irq_disable_reg <= pwdata_in[FLT_COUNT_ERROR_IRQ_DISABLE_BIT];
				fen_reg  <= pwdata_in[FLT_OUTEN_BIT];
				fdiv_reg <= pwdata_in[FLT_DIV_LSB +: 3];
			end
			if (wr_max)
				max_reg <= pwdata_in[15:0];
		end
	end

	// Zero-wait slave: read data is captured in the setup cycle
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~mapped;
			if (setup)
				prdata_reg <= {16'h0000, mapped ? rd_word : 16'h0000};
		end
	end

	assign prdata_out                = prdata_reg;
	assign pready_out                = pready_reg;
	assign pslverr_out               = pslverr_reg;
	assign count_direction_out       = dir_reg;
	assign module_interrupt_flag_out = irq_reg;
	assign count_error_flag_out      = count_error_flag_reg;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence fwd_step_s;
		is_x4 && ea && !eb && (ph_a != ph_b);
	endsequence
	sequence wrap_up_s;
		max_mode && step && up && at_top && !wr_pos;
	endsequence

	dir_forward_a: assert property (fwd_step_s |=> count_direction_out)
		else $error("forward step did not set direction");
	err_sticky_a: assert property (count_error_flag_reg && !(wr_ctrl && !pwdata_in[CTRL_ERR_BIT])
		|=> count_error_flag_reg)
		else $error("count error flag dropped without a clear");
	err_set_a: assert property (err_hit |=> count_error_flag_reg && (count_error_irq_disable_reg || irq_reg))
		else $error("count error not flagged");
	count_error_irq_disable_quiet_a: assert property (err_hit && count_error_irq_disable_reg && !irq_reg && !wrap_evt && !idx_qual
		|=> !irq_reg)
		else $error("disabled count error raised interrupt");
	idx_reset_a: assert property (idx_qual && index_reset_enable_reg && !wr_pos
		|=> pos_reg == 16'h0000 && irq_reg)
		else $error("index did not reset count");
	max_wrap_a: assert property (wrap_up_s |=> pos_reg == 16'h0000 && irq_reg)
		else $error("max count did not wrap to zero");
	x2_b_only_a: assert property (is_x2 && eb && !ea && !wr_pos && !idx_qual
		|=> $stable(pos_reg))
		else $error("x2 counted a phase B edge");
	filt_hold_a: assert property (!tick |=> $stable(filt_reg))
		else $error("filter output changed between samples");
	tmr_count_a: assert property (tmr_step && tmr_up && !at_top && !wr_pos
		|=> pos_reg == $past(pos_reg) + 16'h0001)
		else $error("timer did not count phase A edge");

	sequence rev_step_s;
		is_x4 && ea && !eb && (ph_a == ph_b);
	endsequence

	sequence x4_idx_miss_s;
		is_x4 && idx_mode && sel[2] && !prev_reg[2] && !wr_pos && !step
			&& (ph_b != imv_reg[1] || ph_a != imv_reg[0]);
	endsequence

	sequence x2_idx_miss_s;
		is_x2 && idx_mode && sel[2] && !prev_reg[2] && !wr_pos && !step
			&& ((imv_reg[1] ? ph_b : ph_a) != imv_reg[0]);
	endsequence

	sequence tmr_down_s;
		tmr && !dsrc_reg && tmr_step && !dir_reg && !at_zero && !wr_pos;
	endsequence

	dir_reverse_a: assert property (rev_step_s
		|=> !count_direction_out)
		else $error("reverse step did not clear direction");

	err_modes_a: assert property (!idx_mode && !wr_ctrl
		|=> $stable(count_error_flag_reg))
		else $error("count error changed outside index modes");

	err_irq_a: assert property (err_hit && !count_error_irq_disable_reg
		|=> irq_reg)
		else $error("count error raised no interrupt");

	err_up_a: assert property (err_hit && up && !wr_pos && !(idx_qual && index_reset_enable_reg)
		|=> pos_reg == $past(pos_reg) + 16'h0001)
		else $error("count stopped after up count error");

	err_down_a: assert property (err_hit && !up && !wr_pos && !(idx_qual && index_reset_enable_reg)
		|=> pos_reg == $past(pos_reg) - 16'h0001)
		else $error("count stopped after down count error");

	idx_irq_only_a: assert property (idx_mode && !irq_reg && !idx_qual && !err_hit
		|=> !irq_reg)
		else $error("index mode raised interrupt on rollover");

	err_clear_a: assert property (count_error_flag_reg && wr_ctrl && !pwdata_in[CTRL_ERR_BIT] && !err_hit
		|=> !count_error_flag_reg)
		else $error("count error flag did not clear");

	idx_keep_a: assert property (idx_qual && !index_reset_enable_reg && !wr_pos && !step
		|=> $stable(pos_reg))
		else $error("index reset with reset disabled");

	x4_idx_miss_a: assert property (x4_idx_miss_s
		|=> $stable(pos_reg))
		else $error("x4 index reset without phase match");

	x2_idx_miss_a: assert property (x2_idx_miss_s
		|=> $stable(pos_reg))
		else $error("x2 index reset without phase match");

	idx_irq_a: assert property (idx_qual
		|=> irq_reg)
		else $error("qualified index raised no interrupt");

	dir_mirror_a: assert property (enc_step
		|=> count_direction_out == $past(enc_up))
		else $error("direction output not updated");

	x2_a_edge_a: assert property (is_x2 && ea && up && !at_top && !wr_pos && !idx_qual
		|=> pos_reg == $past(pos_reg) + 16'h0001)
		else $error("x2 missed a phase A edge");

	x2_max_wrap_a: assert property (mode_reg == MODE_X2_MAX && step && up && at_top && !wr_pos
		|=> pos_reg == 16'h0000)
		else $error("x2 max mode did not wrap");

	x2_idx_reset_a: assert property (mode_reg == MODE_X2_INDEX && idx_qual && index_reset_enable_reg && !wr_pos
		|=> pos_reg == 16'h0000)
		else $error("x2 index mode did not reset");

	x4_b_edge_a: assert property (is_x4 && eb && !ea && up && !at_top && !wr_pos && !idx_qual
		|=> pos_reg == $past(pos_reg) + 16'h0001)
		else $error("x4 missed a phase B edge");

	x4_both_a: assert property (is_x4 && ea && eb && !wr_pos && !idx_qual
		|=> $stable(pos_reg))
		else $error("x4 counted a double edge");

	max_no_idx_a: assert property (max_mode && sel[2] && !prev_reg[2] && !wr_pos && !step
		|=> $stable(pos_reg))
		else $error("max mode reset on index");

	filt_three_a: assert property (tick && clean_reg[0] != filt_reg[0] && h1_reg[0] != clean_reg[0]
		|=> filt_reg[0] == $past(filt_reg[0]))
		else $error("filter passed an unconfirmed change");

	tick_gap_a: assert property (tick && fdiv_reg != 3'h0 && !wr_flt
		|=> !tick)
		else $error("filter clock ticked too soon");

	tick_every_a: assert property (fdiv_reg == 3'h0
		|-> tick)
		else $error("undivided filter clock missed a tick");

	tmr_fall_a: assert property (tmr && ea && !ph_a && !wr_pos
		|=> $stable(pos_reg))
		else $error("timer counted a falling edge");

	tmr_period_a: assert property (tmr && step && up && at_top && !wr_pos
		|=> pos_reg == 16'h0000 && irq_reg)
		else $error("timer period match missed");

	mode_keep_a: assert property (wr_ctrl && !wr_pos && !step && !idx_qual
		|=> $stable(pos_reg))
		else $error("mode change altered the count");

	tmr_src_pin_a: assert property (tmr && dsrc_reg && tmr_step && !ph_b && !at_zero && !wr_pos
		|=> pos_reg == $past(pos_reg) - 16'h0001)
		else $error("timer ignored phase B direction");

	tmr_down_a: assert property (tmr_down_s
		|=> pos_reg == $past(pos_reg) - 16'h0001)
		else $error("timer ignored direction bit");

	sync_agree_a: assert property (!fen_reg && $stable(fen_reg) && ea
		|-> s3_reg[0] == ph_a)
		else $error("phase A used before synchroniser agreed");

	flag_clear_a: assert property (irq_reg && wr_flag && !pwdata_in[0] && !irq_set
		|=> !irq_reg)
		else $error("interrupt flag did not clear");

	flag_hold_a: assert property (irq_reg && !wr_flag
		|=> irq_reg)
		else $error("interrupt flag dropped by itself");

endmodule
`default_nettype wire

// ### tb/encoder_model.sv
`default_nettype none
module encoder_model (
	input  wire logic sys_clk_in,
	output logic      phase_a_out,
	output logic      phase_b_out,
	output logic      index_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_pos;
	initial begin
		phase_pos   = 2'h0;
		phase_a_out = 1'b0;
		phase_b_out = 1'b0;
		index_out   = 1'b0;
	end
	// Forward walks 00, A, AB, B so A leads B; edges spaced past the input sync delay
	task automatic step(input logic fwd);
		@(posedge sys_clk_in);
		phase_pos = fwd ? phase_pos + 2'h1 : phase_pos - 2'h1;
		phase_a_out <= ^phase_pos;
		phase_b_out <= phase_pos[1];
		repeat (8) @(posedge sys_clk_in);
	endtask
	task automatic steps(input logic fwd, input int n);
		repeat (n) step(fwd);
	endtask
	task automatic pulse_index();
		@(posedge sys_clk_in);
		index_out <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		index_out <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
	endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench;
	import enc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_in, rst_in, psel_in, penable_in, pwrite_in;
	logic [15:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic        pready_out, pslverr_out, err;
	logic        phase_a_input_in, phase_b_input_in, index_input_in;
	logic        count_direction_out, module_interrupt_flag_out, count_error_flag_out;
	int          n_errors, checks;

	quad_encoder u_dut (.sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .phase_a_input_in,
		.phase_b_input_in, .index_input_in, .count_direction_out,
		.module_interrupt_flag_out, .count_error_flag_out);
	encoder_model u_enc (.sys_clk_in, .phase_a_out(phase_a_input_in),
		.phase_b_out(phase_b_input_in), .index_out(index_input_in));

	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	task automatic close_out();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Zero wait states are expected, but the wait is bounded rather than assumed
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] wd,
			output logic [31:0] rdat, output logic rerr);
		int n;
		@(posedge sys_clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= wr;
		paddr_in   <= {2'h0, idx, 2'h0};
		pwdata_in  <= {16'h0000, wd};
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(negedge sys_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready_out});
		rdat = prdata_out;
		rerr = pslverr_out;
		@(posedge sys_clk_in);
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d, rd, err);
	endtask

	task automatic rd_chk(input string what, input logic [11:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 16'h0000, rd, err);
		chk(what, exp, rd);
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_in);
		n_errors++;
		close_out();
	end

	initial begin
		rst_in     = 1'b1;
		psel_in    = 1'b0;
		penable_in = 1'b0;
		pwrite_in  = 1'b0;
		paddr_in   = 16'h0000;
		pwdata_in  = 32'h0000_0000;
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rd_chk("control", IDX_CONTROL, {16'h0, CONTROL_RESET});
		rd_chk("filter", IDX_FILTER, {16'h0, FILTER_RESET});
		rd_chk("position", IDX_POSITION, {16'h0, POSITION_RESET});
		rd_chk("maximum", IDX_MAXIMUM, {16'h0, MAXIMUM_RESET});
		apb(1'b0, 12'h130, 16'h0000, rd, err);
		chk("unmapped pslverr", 32'h1, {31'h0, err});
		wr(IDX_CONTROL, 16'h0700);
		u_enc.steps(1'b1, 4);
		rd_chk("x4 count", IDX_POSITION, 32'h4);
		rd_chk("direction bit", IDX_CONTROL, 32'h0F00);
		chk("direction pin", 32'h1, {31'h0, count_direction_out});
		u_enc.steps(1'b0, 5);
		rd_chk("underflow", IDX_POSITION, 32'hFFFF);
		chk("reverse pin", 32'h0, {31'h0, count_direction_out});
		chk("rollover flag", 32'h1, {31'h0, module_interrupt_flag_out});
		wr(IDX_IRQ_FLAG, 16'h0000);
		rd_chk("flag clear", IDX_IRQ_FLAG, 32'h0);
		wr(IDX_POSITION, 16'h0000);
		wr(IDX_CONTROL, 16'h0500);
		u_enc.steps(1'b1, 4);
		rd_chk("x2 count", IDX_POSITION, 32'h2);
		wr(IDX_MAXIMUM, 16'h0003);
		wr(IDX_POSITION, 16'h0000);
		wr(IDX_CONTROL, 16'h0700);
		u_enc.steps(1'b1, 4);
		rd_chk("wrap up", IDX_POSITION, 32'h0);
		u_enc.steps(1'b0, 1);
		rd_chk("wrap down", IDX_POSITION, 32'h3);
		wr(IDX_POSITION, 16'h0002);
		wr(IDX_CONTROL, 16'h0600);
		u_enc.steps(1'b1, 2);
		rd_chk("past max", IDX_POSITION, 32'h4);
		chk("error pin", 32'h1, {31'h0, count_error_flag_out});
		rd_chk("error bit", IDX_CONTROL, 32'h8E00);
		wr(IDX_CONTROL, 16'h0604);
		rd_chk("error clear", IDX_CONTROL, 32'h0E04);
		wr(IDX_IRQ_FLAG, 16'h0000);
		u_enc.pulse_index();
		rd_chk("index reset", IDX_POSITION, 32'h0);
		chk("index flag", 32'h1, {31'h0, module_interrupt_flag_out});
		wr(IDX_IRQ_FLAG, 16'h0000);
		wr(IDX_FILTER, 16'h0400);
		u_enc.steps(1'b1, 1);
		u_enc.pulse_index();
		rd_chk("index mismatch", IDX_POSITION, 32'h1);
		chk("mismatch flag", 32'h0, {31'h0, module_interrupt_flag_out});
		wr(IDX_CONTROL, 16'h0900);
		rd_chk("count kept", IDX_POSITION, 32'h1);
		u_enc.steps(1'b1, 12);
		rd_chk("period wrap", IDX_POSITION, 32'h0);
		chk("period flag", 32'h1, {31'h0, module_interrupt_flag_out});
		wr(IDX_CONTROL, 16'h0100);
		u_enc.steps(1'b1, 4);
		rd_chk("timer down", IDX_POSITION, 32'h3);
		wr(IDX_CONTROL, 16'h0700);
		wr(IDX_POSITION, 16'h0000);
		wr(IDX_FILTER, 16'h00F0);
		rd_chk("filter on", IDX_FILTER, 32'h00F0);
		u_enc.steps(1'b1, 1);
		rd_chk("filter holds", IDX_POSITION, 32'h0);
		repeat (400) @(posedge sys_clk_in);
		rd_chk("filter passes", IDX_POSITION, 32'h1);
		close_out();
	end
endmodule
`default_nettype wire
